// ===== verilog/fsc_fan_ctrl.sv
// Purpose: Reversible hydraulic fan speed control with ramped valve command
// Assumes: Input levels are synchronous fractions, 1.0 at FSC_ONE
// Notes: Setpoints live in an Avalon-MM slave; timers count 1 ms ticks
`timescale 1ns/1ps
`include "fsc_defs.svh"

module fsc_fan_ctrl #(
	parameter int TICK_CYCLES = `FSC_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Normalized temperature channels
	input wire logic [15:0] temp_level_1,
	input wire logic [15:0] temp_level_2,
	input wire logic [15:0] temp_level_3,
	input wire logic [15:0] temp_level_4,
	// Override, reverse and halt
	input wire logic [15:0] override_level,
	input wire logic reverse_request,
	input wire logic halt_request,
	// Valve driver outputs
	output logic [15:0] prop_valve_cmd,
	output logic reverse_valve_dir
);
	localparam int NCH = 4;
	localparam int TW = $clog2(TICK_CYCLES + 1);

	// Setpoint registers
	logic [31:0] ctrl_q, ctrl_d, speed_q, speed_d;
	logic [`FSC_TIME_W-1:0] rise_q, rise_d, fall_q, fall_d, sw_q, sw_d, hold_q, hold_d;
	logic [31:0] thr_q [NCH];
	logic [31:0] thr_d [NCH];
	// Bus state
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d, rd_mux;
	logic take, commit;
	// Control path
	logic [TW-1:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	fsc_pkg::fsc_state_e state_q, state_d;
	logic [`FSC_TIME_W-1:0] timer_q, timer_d;
	logic dir_q, dir_d;
	logic [31:0] cmd_q, cmd_d;
	fsc_pkg::fsc_level_t demand_q, demand_d, ctrl_lvl_q, ctrl_lvl_d;
	// Combinational helpers
	fsc_pkg::fsc_level_t tin [NCH];
	fsc_pkg::fsc_level_t ch_lvl [NCH];
	logic [31:0] ch_num [NCH];
	logic [31:0] ch_den [NCH];
	logic [31:0] ch_quot [NCH];
	fsc_pkg::fsc_level_t upper, lower, span, ovr, mx, sel, tgt;
	logic [31:0] span_num, rise_step, fall_step, prod, tgt32, diff;
	logic [32:0] sum;
	logic [16:0] dem_sum;
	logic [2:0] prio;
	logic rev_act, halt_act, cmd_zero;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic fsc_pkg::fsc_level_t sat(input logic [15:0] v);
		return (v > `FSC_ONE) ? `FSC_ONE : v;
	endfunction

	// Channel scaling: (t - low) / (high - low), clamped to one
	assign tin[0] = sat(temp_level_1);
	assign tin[1] = sat(temp_level_2);
	assign tin[2] = sat(temp_level_3);
	assign tin[3] = sat(temp_level_4);

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic [15:0] lo, hi, dt;
		assign lo = thr_q[i][15:0];
		assign hi = thr_q[i][31:16];
		assign dt = (tin[i] > lo) ? (tin[i] - lo) : 16'h0000;
		assign ch_num[i] = {1'b0, dt, 15'h0000};
		assign ch_den[i] = {16'h0000, (hi > lo) ? (hi - lo) : 16'h0001};
		fsc_div #(.W(32)) u_div (
			.clk(clk),
			.srst(srst),
			.num(ch_num[i]),
			.den(ch_den[i]),
			.quot(ch_quot[i])
		);
		// At low threshold level 0, at high threshold level 1
		assign ch_lvl[i] = (ch_quot[i] > {16'h0000, `FSC_ONE}) ? `FSC_ONE :
			ch_quot[i][15:0];
	end

	// Ramp steps per tick: span scaled by 2^16 over duration in ticks
	assign upper = speed_q[31:16];
	assign lower = speed_q[15:0];
	assign span = (upper > lower) ? (upper - lower) : 16'h0000;
	assign span_num = {span, 16'h0000};

	fsc_div #(.W(32)) u_rise (
		.clk(clk),
		.srst(srst),
		.num(span_num),
		.den({8'h00, rise_q}),
		.quot(rise_step)
	);

	fsc_div #(.W(32)) u_fall (
		.clk(clk),
		.srst(srst),
		.num(span_num),
		.den({8'h00, fall_q}),
		.quot(fall_step)
	);

	// Avalon-MM slave: one wait cycle, then answer
	assign take = (avs_read || avs_write) && wait_q;
	assign commit = avs_write && !wait_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			`FSC_OFS_CTRL: rd_mux = ctrl_q;
			`FSC_OFS_SPEED: rd_mux = speed_q;
			`FSC_OFS_RISE: rd_mux = {8'h00, rise_q};
			`FSC_OFS_FALL: rd_mux = {8'h00, fall_q};
			`FSC_OFS_SWITCH: rd_mux = {8'h00, sw_q};
			`FSC_OFS_HOLD: rd_mux = {8'h00, hold_q};
			`FSC_OFS_STATUS: rd_mux = {15'h0000, dir_q, cmd_q[31:16]};
			`FSC_OFS_LEVELS: rd_mux = {demand_q, ctrl_lvl_q};
			default: begin
				for (int i = 0; i < NCH; i++) begin
					if (avs_address == 8'(`FSC_OFS_THR0 + `FSC_THR_STRIDE * i)) begin
						rd_mux = thr_q[i];
					end
				end
			end
		endcase
	end

	always_comb begin
		wait_d = !take;
		rdata_d = (take && avs_read) ? rd_mux : rdata_q;
		ctrl_d = ctrl_q;
		speed_d = speed_q;
		rise_d = rise_q;
		fall_d = fall_q;
		sw_d = sw_q;
		hold_d = hold_q;
		thr_d = thr_q;
		if (commit) begin
			unique case (avs_address)
				`FSC_OFS_CTRL: begin
					ctrl_d = be_merge(ctrl_q, avs_writedata, avs_byteenable) & `FSC_CTRL_MASK;
					if (ctrl_d[`FSC_CTRL_PRIO_HI:`FSC_CTRL_PRIO_LO] > `FSC_PRIO_MAX) begin
						ctrl_d[`FSC_CTRL_PRIO_HI:`FSC_CTRL_PRIO_LO] = `FSC_PRIO_NONE;
					end
				end
				`FSC_OFS_SPEED: speed_d = be_merge(speed_q, avs_writedata, avs_byteenable);
				`FSC_OFS_RISE: rise_d = 24'(be_merge({8'h00, rise_q}, avs_writedata,
					avs_byteenable));
				`FSC_OFS_FALL: fall_d = 24'(be_merge({8'h00, fall_q}, avs_writedata,
					avs_byteenable));
				`FSC_OFS_SWITCH: sw_d = 24'(be_merge({8'h00, sw_q}, avs_writedata,
					avs_byteenable));
				`FSC_OFS_HOLD: hold_d = 24'(be_merge({8'h00, hold_q}, avs_writedata,
					avs_byteenable));
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if (avs_address == 8'(`FSC_OFS_THR0 + `FSC_THR_STRIDE * i)) begin
							thr_d[i] = be_merge(thr_q[i], avs_writedata, avs_byteenable);
						end
					end
				end
			endcase
		end
	end

	// Input conditioning and controlling level
	assign prio = ctrl_q[`FSC_CTRL_PRIO_HI:`FSC_CTRL_PRIO_LO];
	assign ovr = !ctrl_q[`FSC_CTRL_OVR_CON] ? 16'h0000 :
		(ctrl_q[`FSC_CTRL_OVR_INV] ? (`FSC_ONE - sat(override_level)) :
		sat(override_level));
	assign rev_act = ctrl_q[`FSC_CTRL_REV_CON] &&
		(reverse_request ^ ctrl_q[`FSC_CTRL_REV_INV]);
	assign halt_act = ctrl_q[`FSC_CTRL_HALT_CON] &&
		(halt_request ^ ctrl_q[`FSC_CTRL_HALT_INV]);

	always_comb begin
		mx = ch_lvl[0];
		for (int i = 1; i < NCH; i++) begin
			if (ch_lvl[i] > mx) begin
				mx = ch_lvl[i];
			end
		end
		if (prio == `FSC_PRIO_NONE) begin
			sel = mx;
		end else if (mx >= `FSC_ONE) begin
			sel = `FSC_ONE;
		end else begin
			sel = ch_lvl[2'(prio - 3'h1)];
		end
		ctrl_lvl_d = (ovr > sel) ? ovr : sel;
		prod = {16'h0000, span} * {16'h0000, ctrl_lvl_q};
		dem_sum = {1'b0, lower} + {1'b0, prod[30:15]};
		demand_d = dem_sum[15:0];
	end

	// Control tick
	assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
	assign tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;

	// Direction sequencer
	assign cmd_zero = (cmd_q == 32'h0000_0000);

	always_comb begin
		state_d = state_q;
		timer_d = (tick && timer_q != '1) ? timer_q + 1'b1 : timer_q;
		dir_d = dir_q;
		unique case (state_q)
			fsc_pkg::FSC_FWD: begin
				if (rev_act) begin
					state_d = fsc_pkg::FSC_TO_REV_DOWN;
				end
			end
			fsc_pkg::FSC_TO_REV_DOWN: begin
				if (!rev_act) begin
					state_d = fsc_pkg::FSC_FWD;
				end else if (cmd_zero) begin
					state_d = fsc_pkg::FSC_TO_REV_WAIT;
					timer_d = '0;
				end
			end
			fsc_pkg::FSC_TO_REV_WAIT: begin
				if (!rev_act) begin
					state_d = fsc_pkg::FSC_FWD;
				end else if (timer_q >= sw_q) begin
					state_d = fsc_pkg::FSC_REV;
					dir_d = 1'b1;
				end
			end
			fsc_pkg::FSC_REV: begin
				if (!rev_act) begin
					state_d = fsc_pkg::FSC_REV_HOLD;
					timer_d = '0;
				end
			end
			fsc_pkg::FSC_REV_HOLD: begin
				if (rev_act) begin
					state_d = fsc_pkg::FSC_REV;
				end else if (timer_q >= hold_q) begin
					state_d = fsc_pkg::FSC_TO_FWD_DOWN;
				end
			end
			fsc_pkg::FSC_TO_FWD_DOWN: begin
				if (rev_act) begin
					state_d = fsc_pkg::FSC_REV;
				end else if (cmd_zero) begin
					state_d = fsc_pkg::FSC_TO_FWD_WAIT;
					timer_d = '0;
				end
			end
			fsc_pkg::FSC_TO_FWD_WAIT: begin
				if (timer_q >= sw_q) begin
					state_d = fsc_pkg::FSC_FWD;
					dir_d = 1'b0;
				end
			end
		endcase
	end

	// Command target and ramp; halt leaves the direction alone
	always_comb begin
		unique case (state_q)
			fsc_pkg::FSC_FWD: tgt = demand_q;
			fsc_pkg::FSC_REV, fsc_pkg::FSC_REV_HOLD: tgt = `FSC_ONE;
			default: tgt = 16'h0000;
		endcase
		if (halt_act) begin
			tgt = 16'h0000;
		end
		tgt32 = {tgt, 16'h0000};
		sum = {1'b0, cmd_q} + {1'b0, rise_step};
		diff = cmd_q - tgt32;
		cmd_d = cmd_q;
		if (tick) begin
			if (cmd_q < tgt32) begin
				cmd_d = (sum > {1'b0, tgt32}) ? tgt32 : sum[31:0];
			end else if (cmd_q > tgt32) begin
				cmd_d = (diff <= fall_step) ? tgt32 : cmd_q - fall_step;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			ctrl_q <= `FSC_CTRL_DEF;
			speed_q <= {`FSC_UPPER_DEF, `FSC_LOWER_DEF};
			rise_q <= `FSC_RISE_MS_DEF;
			fall_q <= `FSC_FALL_MS_DEF;
			sw_q <= `FSC_SWITCH_MS_DEF;
			hold_q <= `FSC_HOLD_MS_DEF;
			for (int i = 0; i < NCH; i++) begin
				thr_q[i] <= {16'(`FSC_HIGH_LVL_DEF), 16'(`FSC_LOW_LVL_DEF)};
			end
			tick_cnt_q <= '0;
			state_q <= fsc_pkg::FSC_FWD;
			timer_q <= '0;
			dir_q <= 1'b0;
			cmd_q <= 32'h0000_0000;
			demand_q <= 16'h0000;
			ctrl_lvl_q <= 16'h0000;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			speed_q <= speed_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
			sw_q <= sw_d;
			hold_q <= hold_d;
			thr_q <= thr_d;
			tick_cnt_q <= tick_cnt_d;
			state_q <= state_d;
			timer_q <= timer_d;
			dir_q <= dir_d;
			cmd_q <= cmd_d;
			demand_q <= demand_d;
			ctrl_lvl_q <= ctrl_lvl_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign prop_valve_cmd = cmd_q[31:16];
	assign reverse_valve_dir = dir_q;
endmodule

// ===== verilog/fsc_defs.svh
// Purpose: Constants of the reversible fan speed control block
// Assumes: Levels are unsigned fractions with 1.0 at FSC_ONE
// Notes: Byte addresses on the Avalon-MM slave, one word per register
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// Level format
`define FSC_LVL_W 16
`define FSC_ONE 16'h8000
`define FSC_ONE_INT 32768
`define FSC_FRAC_SH 15
`define FSC_ACC_FRAC 16

// Clock and control tick
`define FSC_CLK_HZ 20000000
`define FSC_TICK_US 1000
`define FSC_TICK_CYCLES ((`FSC_CLK_HZ / 1000000) * `FSC_TICK_US)

// Timing defaults in ms (10.0 s, 10.0 s, 1.0 s, 0.0 s)
`define FSC_TIME_W 24
`define FSC_RISE_MS_DEF 24'h00_2710
`define FSC_FALL_MS_DEF 24'h00_2710
`define FSC_SWITCH_MS_DEF 24'h00_03e8
`define FSC_HOLD_MS_DEF 24'h00_0000

// Speed signal defaults (1.0 and 0.1)
`define FSC_UPPER_DEF 16'h8000
`define FSC_LOWER_DEF 16'h0ccd

// Temperature defaults in deg C
`define FSC_TMIN_DEF 20
`define FSC_TLOW_DEF 80
`define FSC_THIGH_DEF 100
`define FSC_TMAX_DEF 120
`define FSC_LOW_LVL_DEF \
	(((`FSC_TLOW_DEF - `FSC_TMIN_DEF) * `FSC_ONE_INT) / (`FSC_TMAX_DEF - `FSC_TMIN_DEF))
`define FSC_HIGH_LVL_DEF \
	(((`FSC_THIGH_DEF - `FSC_TMIN_DEF) * `FSC_ONE_INT) / (`FSC_TMAX_DEF - `FSC_TMIN_DEF))

// Register byte offsets
`define FSC_OFS_CTRL 8'h00
`define FSC_OFS_SPEED 8'h04
`define FSC_OFS_RISE 8'h08
`define FSC_OFS_FALL 8'h0c
`define FSC_OFS_SWITCH 8'h10
`define FSC_OFS_HOLD 8'h14
`define FSC_OFS_THR0 8'h18
`define FSC_OFS_STATUS 8'h28
`define FSC_OFS_LEVELS 8'h2c
`define FSC_THR_STRIDE 8'h04

// Control register fields
`define FSC_CTRL_PRIO_HI 2
`define FSC_CTRL_PRIO_LO 0
`define FSC_CTRL_OVR_CON 3
`define FSC_CTRL_OVR_INV 4
`define FSC_CTRL_REV_CON 5
`define FSC_CTRL_REV_INV 6
`define FSC_CTRL_HALT_CON 7
`define FSC_CTRL_HALT_INV 8
`define FSC_CTRL_MASK 32'h0000_01ff
`define FSC_CTRL_DEF 32'h0000_0000
`define FSC_PRIO_NONE 3'h0
`define FSC_PRIO_MAX 3'h4

`endif

// ===== verilog/fsc_pkg.sv
// Purpose: Types of the reversible fan speed control block
// Assumes: Constants come from fsc_defs.svh
// Notes: Nothing here is imported; use fsc_pkg::name
package fsc_pkg;

	typedef logic [15:0] fsc_level_t;

	typedef enum logic [2:0] {
		FSC_FWD,
		FSC_TO_REV_DOWN,
		FSC_TO_REV_WAIT,
		FSC_REV,
		FSC_REV_HOLD,
		FSC_TO_FWD_DOWN,
		FSC_TO_FWD_WAIT
	} fsc_state_e;

endpackage

// ===== verilog/fsc_div.sv
// Purpose: Free running serial unsigned divider
// Assumes: Operands are sampled at the start of each pass
// Notes: New quotient every W+1 cycles; divide by zero gives all ones
`timescale 1ns/1ps
module fsc_div #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Operands
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	// Result
	output logic [W-1:0] quot
);
	localparam int CW = $clog2(W) + 1;

	logic [W-1:0] n_q, n_d, d_q, d_d, q_q, q_d, quot_q, quot_d;
	logic [W:0] r_q, r_d, r_sh;
	logic [CW-1:0] cnt_q, cnt_d;
	logic qbit;

	always_comb begin
		n_d = n_q;
		d_d = d_q;
		q_d = q_q;
		r_d = r_q;
		cnt_d = cnt_q;
		quot_d = quot_q;
		r_sh = {r_q[W-1:0], n_q[W-1]};
		qbit = (r_sh >= {1'b0, d_q});
		if (cnt_q == '0) begin
			n_d = num;
			d_d = den;
			q_d = '0;
			r_d = '0;
			cnt_d = CW'(W);
		end else begin
			n_d = {n_q[W-2:0], 1'b0};
			q_d = {q_q[W-2:0], qbit};
			r_d = qbit ? (r_sh - {1'b0, d_q}) : r_sh;
			cnt_d = cnt_q - 1'b1;
			if (cnt_q == CW'(1)) begin
				quot_d = (d_q == '0) ? '1 : {q_q[W-2:0], qbit};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			n_q <= '0;
			d_q <= '0;
			q_q <= '0;
			r_q <= '0;
			cnt_q <= '0;
			quot_q <= '0;
		end else begin
			n_q <= n_d;
			d_q <= d_d;
			q_q <= q_d;
			r_q <= r_d;
			cnt_q <= cnt_d;
			quot_q <= quot_d;
		end
	end

	assign quot = quot_q;
endmodule

// ===== test/fsc_fan_ctrl_properties.sv
// Purpose: Port properties of the fan speed control block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound into fsc_fan_ctrl below the module
`timescale 1ns/1ps
module fsc_fan_ctrl_props #(
	parameter int TICK_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Control inputs
	input wire logic [15:0] temp_level_1,
	input wire logic [15:0] temp_level_2,
	input wire logic [15:0] temp_level_3,
	input wire logic [15:0] temp_level_4,
	input wire logic [15:0] override_level,
	input wire logic reverse_request,
	input wire logic halt_request,
	// Valve outputs
	input wire logic [15:0] prop_valve_cmd,
	input wire logic reverse_valve_dir
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic [15:0] cmd_q;
	int since_q;
	int since_d;
	// Cycles since the command last moved
	always_comb begin
		since_d = (since_q < TICK_CYCLES) ? since_q + 1 : since_q;
		if (prop_valve_cmd != cmd_q) begin
			since_d = 0;
		end
	end
	always_ff @(posedge clk) begin
		cmd_q <= prop_valve_cmd;
		since_q <= srst ? TICK_CYCLES : since_d;
	end
	a_reset_idle: assert property ($fell(srst) |-> avs_waitrequest
		&& avs_readdata == 32'h0000_0000 && prop_valve_cmd == 16'h0000 && !reverse_valve_dir)
		else $error("state after reset wrong");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without request");
	a_rdata_hold: assert property ($changed(avs_readdata) |-> $fell(avs_waitrequest) && $past(avs_read))
		else $error("read data moved outside a read answer");
	a_cmd_bound: assert property (prop_valve_cmd <= 16'h8000)
		else $error("command above full scale");
	a_dir_at_zero: assert property ($changed(reverse_valve_dir) |-> $past(prop_valve_cmd) == 16'h0000)
		else $error("direction switched with valve open");
	a_ramp_tick: assert property (prop_valve_cmd != cmd_q |-> since_q >= TICK_CYCLES - 1)
		else $error("command moved between ticks");
	c_read: cover property (avs_read && !avs_waitrequest);
	c_reverse: cover property ($rose(reverse_valve_dir));
	c_full: cover property (prop_valve_cmd == 16'h8000);
endmodule
bind fsc_fan_ctrl fsc_fan_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (.clk(clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .temp_level_1(temp_level_1), .temp_level_2(temp_level_2),
	.temp_level_3(temp_level_3), .temp_level_4(temp_level_4), .override_level(override_level),
	.reverse_request(reverse_request), .halt_request(halt_request),
	.prop_valve_cmd(prop_valve_cmd), .reverse_valve_dir(reverse_valve_dir));

// ===== test/fsc_valve_model.sv
// Purpose: Valve driver model at the far side of the fan control
// Assumes: Command is a fraction with 1.0 at 16'h8000
// Notes: Latches a direction swap made while the valve carries flow
`timescale 1ns/1ps
module fsc_valve_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// From the fan control
	input wire logic [15:0] cmd,
	input wire logic dir,
	// Valve drive
	output logic pwm_prop,
	output logic pwm_rev,
	output logic shock
);
	logic [15:0] cnt_q;
	logic dir_q;
	always_ff @(posedge clk) begin
		cnt_q <= srst ? 16'h0000 : (cnt_q + 16'h0200) & 16'h7fff;
		dir_q <= dir;
		shock <= srst ? 1'b0 : shock | ((dir != dir_q) && (cmd != 16'h0000));
	end
	assign pwm_prop = cnt_q < cmd;
	assign pwm_rev = dir_q;
endmodule

// ===== test/fsc_fan_ctrl_tb_top.sv
// Purpose: Self-checking bench of the fan speed control block
// Assumes: Short control tick; bus answers after one wait cycle
// Notes: Thresholds are reprogrammed so channel levels are easy to predict
`timescale 1ns/1ps
`include "fsc_defs.svh"
module fsc_fan_ctrl_tb_top;
	localparam int TC = 20;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] temp_lvl [4] = '{default: 16'h0000};
	logic [15:0] override_level = 16'h0000;
	logic reverse_request = 1'b0;
	logic halt_request = 1'b0;
	logic [15:0] prop_valve_cmd;
	logic reverse_valve_dir;
	logic pwm_prop;
	logic pwm_rev;
	logic shock;
	logic [31:0] rd_q;
	int n;
	int bad_count = 0;
	int checks_done = 0;
	always #25 clk = ~clk;
	fsc_fan_ctrl #(.TICK_CYCLES(TC)) dut_u (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.temp_level_1(temp_lvl[0]), .temp_level_2(temp_lvl[1]), .temp_level_3(temp_lvl[2]),
		.temp_level_4(temp_lvl[3]), .override_level(override_level),
		.reverse_request(reverse_request), .halt_request(halt_request),
		.prop_valve_cmd(prop_valve_cmd), .reverse_valve_dir(reverse_valve_dir));
	fsc_valve_model valve_u (.clk(clk), .srst(srst), .cmd(prop_valve_cmd), .dir(reverse_valve_dir),
		.pwm_prop(pwm_prop), .pwm_rev(pwm_rev), .shock(shock));
	task automatic conclude();
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		checks_done++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			bad_count++;
			$display("BAD %0t: %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge clk iff avs_waitrequest === 1'b0);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk iff avs_waitrequest === 1'b0);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic tk(input int t);
		repeat (t * TC) @(posedge clk);
	endtask
	task automatic wait_for(input bit on_dir, input logic [15:0] exp);
		n = 0;
		while ((on_dir ? {15'h0000, reverse_valve_dir} : prop_valve_cmd) !== exp && n < 2000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic set_thr(input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			wr(`FSC_OFS_THR0 + 8'(4 * i), v);
		end
	endtask
	task automatic t_defaults();
		rd(`FSC_OFS_CTRL);
		chk_eq(rd_q, 32'h0000_0000);
		rd(`FSC_OFS_SPEED);
		chk_eq(rd_q, 32'h8000_0ccd);
		rd(`FSC_OFS_RISE);
		chk_eq(rd_q, 32'h0000_2710);
		rd(`FSC_OFS_FALL);
		chk_eq(rd_q, 32'h0000_2710);
		rd(`FSC_OFS_SWITCH);
		chk_eq(rd_q, 32'h0000_03e8);
		rd(`FSC_OFS_HOLD);
		chk_eq(rd_q, 32'h0000_0000);
		rd(`FSC_OFS_THR0 + 8'h0c);
		chk_eq(rd_q, 32'h6666_4ccc);
		wr(`FSC_OFS_CTRL, 32'h0000_0005);
		rd(`FSC_OFS_CTRL);
		chk_eq(rd_q, 32'h0000_0000);
		wr(8'h40, 32'h1234_5678);
		rd(8'h40);
		chk_eq(rd_q, 32'h0000_0000);
	endtask
	task automatic sel(input logic [8:0] c, input logic [63:0] t, input logic [15:0] ov, x, y);
		wr(`FSC_OFS_CTRL, {23'h00_0000, c});
		temp_lvl <= '{t[63:48], t[47:32], t[31:16], t[15:0]};
		override_level <= ov;
		tk(6);
		rd(`FSC_OFS_LEVELS);
		chk_eq(rd_q, {y, x});
		chk_eq({16'h0000, prop_valve_cmd}, {16'h0000, y});
	endtask
	task automatic t_select();
		wr(`FSC_OFS_SPEED, 32'h8000_0000);
		wr(`FSC_OFS_RISE, 32'h0000_0000);
		wr(`FSC_OFS_FALL, 32'h0000_0000);
		set_thr(32'h8000_0000);
		sel(9'h000, 64'h1000_3000_2000_0800, 16'h0000, 16'h3000, 16'h3000);
		sel(9'h001, 64'h1000_3000_2000_0800, 16'h0000, 16'h1000, 16'h1000);
		sel(9'h002, 64'h1000_3000_2000_0800, 16'h0000, 16'h3000, 16'h3000);
		sel(9'h003, 64'h1000_3000_2000_0800, 16'h0000, 16'h2000, 16'h2000);
		sel(9'h004, 64'h1000_3000_2000_0800, 16'h0000, 16'h0800, 16'h0800);
		sel(9'h003, 64'h1000_3000_2000_8000, 16'h0000, 16'h8000, 16'h8000);
		sel(9'h008, 64'h1000_3000_2000_0800, 16'h5000, 16'h5000, 16'h5000);
		sel(9'h018, 64'h1000_3000_2000_0800, 16'h6000, 16'h3000, 16'h3000);
		sel(9'h000, 64'h1000_3000_2000_0800, 16'h7000, 16'h3000, 16'h3000);
		set_thr(32'h6000_2000);
		wr(`FSC_OFS_SPEED, 32'h7000_1000);
		sel(9'h000, 64'h1000_0000_0000_0000, 16'h0000, 16'h0000, 16'h1000);
		sel(9'h000, 64'h4000_0000_0000_0000, 16'h0000, 16'h4000, 16'h4000);
		sel(9'h000, 64'h7000_0000_0000_0000, 16'h0000, 16'h8000, 16'h7000);
	endtask
	task automatic t_ramp();
		wr(`FSC_OFS_SPEED, 32'h8000_0000);
		temp_lvl[0] <= 16'h0000;
		tk(6);
		wr(`FSC_OFS_RISE, 32'h0000_0064);
		wr(`FSC_OFS_FALL, 32'h0000_00c8);
		temp_lvl[0] <= 16'h7000;
		tk(50);
		chk_rng({16'h0000, prop_valve_cmd}, 32'h0000_3800, 32'h0000_4200);
		tk(60);
		chk_eq({16'h0000, prop_valve_cmd}, 32'h0000_8000);
		temp_lvl[0] <= 16'h0000;
		tk(100);
		chk_rng({16'h0000, prop_valve_cmd}, 32'h0000_3c00, 32'h0000_4400);
		tk(110);
		chk_eq({16'h0000, prop_valve_cmd}, 32'h0000_0000);
	endtask
	task automatic t_reverse();
		wr(`FSC_OFS_RISE, 32'h0000_0014);
		wr(`FSC_OFS_FALL, 32'h0000_0014);
		wr(`FSC_OFS_SWITCH, 32'h0000_001e);
		wr(`FSC_OFS_HOLD, 32'h0000_0028);
		wr(`FSC_OFS_CTRL, 32'h0000_00a0);
		temp_lvl[0] <= 16'h4000;
		tk(20);
		chk_eq({16'h0000, prop_valve_cmd}, 32'h0000_4000);
		reverse_request <= 1'b1;
		wait_for(1'b0, 16'h0000);
		chk_rng(n, 9 * TC, 13 * TC);
		wait_for(1'b1, 16'h0001);
		chk_rng(n, 29 * TC, 32 * TC);
		tk(25);
		chk_eq({16'h0000, prop_valve_cmd}, 32'h0000_8000);
		halt_request <= 1'b1;
		tk(25);
		chk_eq({15'h0000, reverse_valve_dir, prop_valve_cmd}, 32'h0001_0000);
		halt_request <= 1'b0;
		tk(25);
		reverse_request <= 1'b0;
		tk(35);
		chk_eq({15'h0000, reverse_valve_dir, prop_valve_cmd}, 32'h0001_8000);
		rd(`FSC_OFS_STATUS);
		chk_eq(rd_q, 32'h0001_8000);
		wait_for(1'b0, 16'h0000);
		chk_rng(n, 23 * TC, 28 * TC);
		wait_for(1'b1, 16'h0000);
		chk_rng(n, 29 * TC, 32 * TC);
		tk(25);
		chk_eq({16'h0000, prop_valve_cmd}, 32'h0000_4000);
		wr(`FSC_OFS_CTRL, 32'h0000_01a0);
		tk(25);
		chk_eq({15'h0000, reverse_valve_dir, prop_valve_cmd}, 32'h0000_0000);
		// Inverted reverse input with halt still active
		wr(`FSC_OFS_CTRL, 32'h0000_01e0);
		tk(35);
		chk_eq({15'h0000, reverse_valve_dir, prop_valve_cmd}, 32'h0001_0000);
		chk_eq({31'h0000_0000, pwm_rev}, 32'h0000_0001);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_defaults();
		t_select();
		t_ramp();
		t_reverse();
		chk_eq({31'h0000_0000, shock}, 32'h0000_0000);
		conclude();
	end
endmodule
